// file: ahbp_cfg.svh
// Constants for the asynchronous host bus port: widths, reset values.
`ifndef AHBP_CFG_SVH
`define AHBP_CFG_SVH

// Host address width in bits
`define AHBP_ADDR_W 16
// Host data width in bits, full width only
`define AHBP_DATA_W 16
// Depth of every pin synchroniser in flops
`define AHBP_SYNC_STAGES 2
// Reset value of the read data output register
`define AHBP_RDATA_RST 16'h0000
// Reset value of the captured address register
`define AHBP_ADDR_RST 16'h0000
// Level of the acknowledgement while idle (released)
`define AHBP_ACK_IDLE 1'b1
// Level of the acknowledgement while an access is accepted
`define AHBP_ACK_BUSY 1'b0
// Sampled level of the memory select that means shared memory
`define AHBP_SEL_MEM 1'b1

`endif

// file: ahbp_pkg.sv
// Types shared by the asynchronous host bus port modules.
package ahbp_pkg;

	// Access sequencer states
	typedef enum logic [2:0] {
		AHBP_IDLE  = 3'b000, // Waiting for select and strobe
		AHBP_LATCH = 3'b001, // Falling edge latches target and direction
		AHBP_ACK   = 3'b010, // Acknowledge driven low
		AHBP_ADDR  = 3'b011, // Unused; address and data are latched in AHBP_ACK
		AHBP_XFER  = 3'b100, // Internal request issued
		AHBP_HOLD  = 3'b101  // Waiting for the strobe to return high
	} ahbp_state_t;

endpackage : ahbp_pkg

// file: ahbp_pin_if.sv
// Synchronised host pin levels passed from the synchroniser to the core.
`timescale 1ns/1ps
`default_nettype none
`include "ahbp_cfg.svh"

interface ahbp_pin_if;
	logic sel_n; // Synchronised chip select, active low
	logic access_strobe_n_n; // Synchronised access strobe, active low
	logic mem_sel; // Synchronised memory-or-register select
	logic rd_wr; // Synchronised read/write line, raw sense
	logic pol_sel; // Synchronised direction polarity strap
	logic [`AHBP_ADDR_W-1:0] addr; // Synchronised address
	logic [`AHBP_DATA_W-1:0] wdata; // Synchronised write data

	// Synchroniser side drives every level
	modport sync (
		output sel_n, access_strobe_n_n, mem_sel, rd_wr, pol_sel, addr, wdata
	);
	// Sequencer side only reads
	modport core (
		input sel_n, access_strobe_n_n, mem_sel, rd_wr, pol_sel, addr, wdata
	);
endinterface : ahbp_pin_if

`default_nettype wire

// file: ahbp_sync.sv
// Two-flop synchronisers for every host pin entering the device clock.
`timescale 1ns/1ps
`default_nettype none
`include "ahbp_cfg.svh"

module ahbp_sync
	import ahbp_pkg::*;
(
	input wire logic mclk, // Device clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic select_n, // Host chip select pin
	input wire logic access_strobe_n, // Host access strobe pin
	input wire logic mem_reg_sel, // Host memory-or-register pin
	input wire logic rd_wr, // Host read/write pin
	input wire logic polarity_sel, // Direction polarity strap pin
	input wire logic [`AHBP_ADDR_W-1:0] host_addr, // Host address pins
	input wire logic [`AHBP_DATA_W-1:0] host_wdata, // Host data pins in
	ahbp_pin_if.sync pins // Synchronised levels out
);

	localparam int W = 5 + `AHBP_ADDR_W + `AHBP_DATA_W;

	logic [W-1:0] meta_q; // First stage, read only by second stage
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q; // Second stage, safe to use
	logic [W-1:0] sync_d;
	logic [W-1:0] idle_v; // Reset image: strobes released

	// Reset leaves select and strobe high so no false access follows reset
	assign idle_v = {1'b1, 1'b1, 3'b000, `AHBP_ADDR_W'h0000,
		`AHBP_DATA_W'h0000};

	// Next values of both stages
	always_comb begin
		if (!rst_b) begin
			meta_d = idle_v;
			sync_d = idle_v;
		end else begin
			meta_d = {select_n, access_strobe_n, mem_reg_sel, rd_wr,
				polarity_sel, host_addr, host_wdata};
			sync_d = meta_q;
		end
	end

	// Register both stages
	always_ff @(posedge mclk) begin
		meta_q <= meta_d;
		sync_q <= sync_d;
	end

	// Unpack the second stage only
	assign {pins.sel_n, pins.access_strobe_n_n, pins.mem_sel, pins.rd_wr,
		pins.pol_sel, pins.addr, pins.wdata} = sync_q;

endmodule : ahbp_sync

`default_nettype wire

// file: ahbp_port.sv
// Asynchronous host bus port: sequences host reads and writes inward.
`timescale 1ns/1ps
`default_nettype none
`include "ahbp_cfg.svh"

module ahbp_port
	import ahbp_pkg::*;
#(
	parameter int ADDR_W = `AHBP_ADDR_W, // Host address width
	parameter int DATA_W = `AHBP_DATA_W // Host data width
) (
	input wire logic mclk, // Device clock, 125 MHz
	input wire logic rst_b, // Synchronous reset, active low
	input wire logic master_clear_n, // Master clear pin, active low
	input wire logic select_n, // Host chip select, active low
	input wire logic access_strobe_n, // Host access strobe, active low
	input wire logic mem_reg_sel, // High memory, low registers
	input wire logic rd_wr, // Direction, sense set by strap
	input wire logic polarity_sel, // Direction polarity strap
	input wire logic [ADDR_W-1:0] host_addr, // Host address
	input wire logic [DATA_W-1:0] host_data_i, // Host data in
	output logic [DATA_W-1:0] host_data_o, // Host data out
	output logic host_data_oe, // High while driving data
	output logic io_enable_ack_n, // Access acknowledge, active low
	output logic reg_req, // Register access pulse
	output logic mem_req, // Memory access pulse
	output logic req_write, // Access is a write
	output logic [ADDR_W-1:0] req_addr, // Access address
	output logic [DATA_W-1:0] req_wdata, // Access write data
	input wire logic [DATA_W-1:0] reg_rdata, // Register read data
	input wire logic [DATA_W-1:0] mem_rdata, // Memory read data
	output logic busy // Access in progress
);

	// Master clear is a pin: synchronise before it joins the reset
	logic mclr_meta_q; // First stage, feeds second only
	logic mclr_meta_d;
	logic mclr_q; // Synchronised master clear, active low
	logic mclr_d;
	logic srst_b; // Combined reset, active low

	// Master clear synchroniser next values
	always_comb begin
		if (!rst_b) begin
			mclr_meta_d = 1'b0;
			mclr_d = 1'b0;
		end else begin
			mclr_meta_d = master_clear_n;
			mclr_d = mclr_meta_q;
		end
	end

	// Master clear synchroniser flops
	always_ff @(posedge mclk) begin
		mclr_meta_q <= mclr_meta_d;
		mclr_q <= mclr_d;
	end

	// Master clear resets the port state as the reset does
	assign srst_b = rst_b & mclr_q;

	// Host pins cross into the device clock here
	ahbp_pin_if pins ();

	ahbp_sync u_sync (
		.mclk(mclk),
		.rst_b(rst_b),
		.select_n(select_n),
		.access_strobe_n(access_strobe_n),
		.mem_reg_sel(mem_reg_sel),
		.rd_wr(rd_wr),
		.polarity_sel(polarity_sel),
		.host_addr(host_addr),
		.host_wdata(host_data_i),
		.pins(pins.sync)
	);

	// Decode the raw direction line into read, per the strap
	function automatic logic is_read(input logic line, input logic pol);
		// Strap high: line high reads; strap low: line low reads
		is_read = pol ? line : ~line;
	endfunction : is_read

	// Select and strobe both low; works when tied together
	logic acc_act;
	assign acc_act = ~pins.sel_n & ~pins.access_strobe_n_n;

	// Strobe back high ends the access
	logic acc_end;
	assign acc_end = pins.access_strobe_n_n;

	// Sequencer state
	ahbp_state_t state_q;
	ahbp_state_t state_d;
	logic ack_n_q; // Acknowledge register
	logic ack_n_d;
	logic [ADDR_W-1:0] addr_q; // Latched address
	logic [ADDR_W-1:0] addr_d;
	logic [DATA_W-1:0] wdata_q; // Latched write data
	logic [DATA_W-1:0] wdata_d;
	logic [DATA_W-1:0] rdata_q; // Read data to host
	logic [DATA_W-1:0] rdata_d;
	logic oe_q; // Data output enable
	logic oe_d;
	logic req_q; // One-cycle access pulse
	logic req_d;

	// Falling-edge group: target and direction
	logic mem_q; // Latched target, high memory
	logic mem_d;
	logic rd_q; // Latched direction, high read
	logic rd_d;

	// Falling-edge next values: latch only while in the latch state
	always_comb begin
		mem_d = mem_q;
		rd_d = rd_q;
		if (!srst_b) begin
			mem_d = 1'b0;
			rd_d = 1'b0;
		end else if (state_q == AHBP_LATCH) begin
			// First falling edge after select and strobe low
			mem_d = (pins.mem_sel == `AHBP_SEL_MEM);
			rd_d = is_read(pins.rd_wr, pins.pol_sel);
		end
	end

	// Falling-edge registers; the latch state spans exactly one such edge
	always_ff @(negedge mclk) begin
		mem_q <= mem_d;
		rd_q <= rd_d;
	end

	// Sequencer next values
	always_comb begin
		state_d = state_q;
		ack_n_d = ack_n_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		oe_d = oe_q;
		req_d = 1'b0;
		if (!srst_b) begin
			state_d = AHBP_IDLE;
			ack_n_d = `AHBP_ACK_IDLE;
			addr_d = `AHBP_ADDR_RST;
			wdata_d = `AHBP_DATA_W'h0000;
			rdata_d = `AHBP_RDATA_RST;
			oe_d = 1'b0;
		end else begin
			unique case (state_q)
				AHBP_IDLE: begin
					// Same entry for reads and writes, any target
					if (acc_act) begin
						state_d = AHBP_LATCH;
					end
				end
				AHBP_LATCH: begin
					// Target latched mid-cycle; accept the access
					if (acc_end) begin
						state_d = AHBP_IDLE;
					end else begin
						state_d = AHBP_ACK;
						ack_n_d = `AHBP_ACK_BUSY;
					end
				end
				AHBP_ACK: begin
					// First rising edge after acknowledge low
					addr_d = pins.addr;
					// Write data taken on the same edge
					wdata_d = pins.wdata;
					req_d = 1'b1;
					state_d = AHBP_XFER;
				end
				AHBP_ADDR: begin
					// Unused code; a later edge would break the timing
					state_d = AHBP_IDLE;
				end
				AHBP_XFER: begin
					// Targets answer in the request cycle: no wait states
					if (rd_q) begin
						// Valid on the edge after the address latch
						rdata_d = mem_q ? mem_rdata : reg_rdata;
						oe_d = 1'b1;
					end
					state_d = AHBP_HOLD;
				end
				AHBP_HOLD: begin
					// Hold data and acknowledge until strobe high
					if (acc_end) begin
						ack_n_d = `AHBP_ACK_IDLE;
						oe_d = 1'b0;
						state_d = AHBP_IDLE;
					end
				end
			endcase
			// A strobe released early aborts cleanly without a request
			if (acc_end && (state_q == AHBP_ACK)) begin
				ack_n_d = `AHBP_ACK_IDLE;
				req_d = 1'b0;
				state_d = AHBP_IDLE;
			end
		end
	end

	// Sequencer registers; nothing here depends on the clock rate
	always_ff @(posedge mclk) begin
		state_q <= state_d;
		ack_n_q <= ack_n_d;
		addr_q <= addr_d;
		wdata_q <= wdata_d;
		rdata_q <= rdata_d;
		oe_q <= oe_d;
		req_q <= req_d;
	end

	// Route the pulse to memory or registers
	assign mem_req = req_q & mem_q;
	assign reg_req = req_q & ~mem_q;
	// Writes carry data; targets keep what they get
	assign req_write = ~rd_q;
	assign req_addr = addr_q;
	// Full-width data path only, no byte lane steering
	assign req_wdata = wdata_q;

	// Host side outputs from flops; busy is decoded from state_q
	assign host_data_o = rdata_q;
	assign host_data_oe = oe_q;
	assign io_enable_ack_n = ack_n_q;
	assign busy = (state_q != AHBP_IDLE);

endmodule : ahbp_port

`default_nettype wire

// file: ahbp_port_props.sv
// Handshake checker for the host bus port, bound to ahbp_port.
`timescale 1ns/1ps
`default_nettype none

module ahbp_port_props
	import ahbp_pkg::*;
#(
	parameter int DATA_W = 16 // Host data width
) (
	input wire logic mclk, // Device clock
	input wire logic rst_b, // Reset, active low
	input wire logic access_strobe_n, // Host strobe
	input wire logic io_enable_ack_n, // Acknowledge
	input wire logic host_data_oe, // Data drive enable
	input wire logic [DATA_W-1:0] host_data_o, // Read data out
	input wire logic reg_req, // Register pulse
	input wire logic mem_req, // Memory pulse
	input wire logic req_write, // Write flag
	input wire logic [DATA_W-1:0] reg_rdata, // Register data
	input wire logic [DATA_W-1:0] mem_rdata, // Memory data
	input wire logic busy // Busy flag
);
	// Every check runs on the rising edge; all but p_rst are quiet in reset
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// Strobe released long enough to be seen by the sync chain
	sequence s_access_strobe_n_idle;
		access_strobe_n [*4];
	endsequence
	property p_ack_req;
		$fell(io_enable_ack_n) |=> (reg_req || mem_req);
	endproperty
	property p_one_tgt;
		!(reg_req && mem_req);
	endproperty
	property p_pulse;
		(reg_req || mem_req) |=> !(reg_req || mem_req);
	endproperty
	property p_oe_rd;
		(reg_req || mem_req) && !req_write |=> host_data_oe;
	endproperty
	property p_oe_wr;
		(reg_req || mem_req) && req_write |=> !host_data_oe;
	endproperty
	property p_rd_reg;
		reg_req && !req_write |=> host_data_o == reg_rdata;
	endproperty
	property p_rd_mem;
		mem_req && !req_write |=> host_data_o == mem_rdata;
	endproperty
	property p_rel;
		s_access_strobe_n_idle |-> io_enable_ack_n;
	endproperty
	property p_noreq;
		access_strobe_n [*5] |-> !(reg_req || mem_req);
	endproperty
	// Reset must be checked while it is active
	property p_rst;
		disable iff (1'b0) !rst_b |=> io_enable_ack_n && !host_data_oe && !busy;
	endproperty
	a_ack_req: assert property (p_ack_req) else $error("no request after ack");
	a_one_tgt: assert property (p_one_tgt) else $error("two targets at once");
	a_pulse: assert property (p_pulse) else $error("request too long");
	a_oe_rd: assert property (p_oe_rd) else $error("read not driven");
	a_oe_wr: assert property (p_oe_wr) else $error("write drove data");
	a_rd_reg: assert property (p_rd_reg) else $error("bad register data");
	a_rd_mem: assert property (p_rd_mem) else $error("bad memory data");
	a_rel: assert property (p_rel) else $error("ack not released");
	a_noreq: assert property (p_noreq) else $error("request unasked");
	a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule : ahbp_port_props

bind ahbp_port ahbp_port_props #(.DATA_W(DATA_W)) u_props (.mclk, .rst_b,
	.access_strobe_n, .io_enable_ack_n, .host_data_oe, .host_data_o,
	.reg_req, .mem_req, .req_write, .reg_rdata, .mem_rdata, .busy);

`default_nettype wire

// file: ahbp_host.sv
// Host processor model driving asynchronous port cycles.
`timescale 1ns/1ps
`default_nettype none

module ahbp_host (
	input wire logic mclk, // Device clock, used as host pacing
	input wire logic io_enable_ack_n, // Acknowledge from port
	input wire logic [15:0] host_data_o, // Read data from port
	output logic strobe_n, // Shared select and strobe
	output logic mem_reg_sel, // Target select
	output logic rd_wr, // Direction line
	output logic polarity_sel, // Direction sense strap
	output logic [15:0] host_addr, // Address lines
	output logic [15:0] host_data_i // Write data lines
);
	// Idle pins at time zero
	initial begin
		strobe_n = 1'b1;
		mem_reg_sel = 1'b0;
		rd_wr = 1'b0;
		polarity_sel = 1'b1;
		host_addr = 16'h0000;
		host_data_i = 16'h0000;
	end
	// One access; pins held until ack low plus three cycles
	task automatic cycle(input logic mem, input logic wr, input logic pol,
		input logic [15:0] a, input logic [15:0] d, output logic [15:0] rd);
		int n;
		@(negedge mclk);
		polarity_sel = pol;
		rd_wr = pol ? !wr : wr;
		mem_reg_sel = mem;
		host_addr = a;
		host_data_i = d;
		strobe_n = 1'b0;
		n = 0;
		while (io_enable_ack_n !== 1'b0 && n < 20) begin
			@(negedge mclk);
			n++;
		end
		repeat (3) @(negedge mclk);
		rd = host_data_o;
		strobe_n = 1'b1;
		// Released lines show garbage, not the last value
		host_addr = ~a;
		host_data_i = ~d;
		mem_reg_sel = !mem;
		rd_wr = !rd_wr;
		n = 0;
		while (io_enable_ack_n !== 1'b1 && n < 20) begin
			@(negedge mclk);
			n++;
		end
	endtask : cycle
endmodule : ahbp_host

`default_nettype wire

// file: tb.sv
// Testbench for the host bus port: all target and direction mixes.
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic mclk, rst_b, mclr_n, access_strobe_n_n, mem_sel, rdwr, pol; // Pins
	logic [15:0] addr, wdat, data_o, req_addr, req_wdata, rd, a, d; // Words
	logic oe, ack_n, reg_req, mem_req, req_write, busy; // Outputs
	logic [15:0] reg_rdata, mem_rdata, g_addr, g_wd; // Targets, captures
	logic g_mem, g_wr; // Captured target and direction
	int err_total, comparisons, n_req, i; // Counters

	// Targets answer at once from the address (zero wait)
	assign reg_rdata = req_addr ^ 16'hA5A5;
	assign mem_rdata = req_addr ^ 16'h3C3C;

	initial mclk = 1'b0;
	always #4 mclk = ~mclk;

	// Capture each internal request as it pulses
	initial n_req = 0;
	always @(posedge mclk) begin
		if (reg_req === 1'b1 || mem_req === 1'b1) begin
			g_mem <= mem_req;
			g_wr <= req_write;
			g_addr <= req_addr;
			g_wd <= req_wdata;
			n_req <= n_req + 1;
		end
	end

	ahbp_host host (.mclk(mclk), .io_enable_ack_n(ack_n),
		.host_data_o(data_o), .strobe_n(access_strobe_n_n), .mem_reg_sel(mem_sel),
		.rd_wr(rdwr), .polarity_sel(pol), .host_addr(addr),
		.host_data_i(wdat));

	ahbp_port dut (.mclk(mclk), .rst_b(rst_b), .master_clear_n(mclr_n),
		.select_n(access_strobe_n_n), .access_strobe_n(access_strobe_n_n), .mem_reg_sel(mem_sel),
		.rd_wr(rdwr), .polarity_sel(pol), .host_addr(addr),
		.host_data_i(wdat), .host_data_o(data_o), .host_data_oe(oe),
		.io_enable_ack_n(ack_n), .reg_req(reg_req), .mem_req(mem_req),
		.req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
		.reg_rdata(reg_rdata), .mem_rdata(mem_rdata), .busy(busy));

	// Compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("comparisons %0d errors %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// Back-to-back accesses over polarity, target and direction
	initial begin
		rst_b = 1'b0;
		mclr_n = 1'b1;
		repeat (16) @(negedge mclk);
		rst_b = 1'b1;
		for (i = 0; i < 8; i++) begin
			a = 16'h8E10 + 16'(i);
			d = 16'h5C00 | 16'(i * 7);
			host.cycle(i[0], i[1], i[2], a, d, rd);
			check(16'(n_req), 16'(i + 1));
			check({14'h0000, g_mem, g_wr}, {14'h0000, i[0], i[1]});
			check(g_addr, a);
			if (i[1])
				check(g_wd, d);
			else
				check(rd, a ^ (i[0] ? 16'h3C3C : 16'hA5A5));
		end
		// Master clear holds the port idle
		@(negedge mclk);
		mclr_n = 1'b0;
		repeat (4) @(negedge mclk);
		check({13'h0000, busy, ack_n, oe}, 16'h0002);
		mclr_n = 1'b1;
		repeat (3) @(negedge mclk);
		host.cycle(1'b1, 1'b0, 1'b1, 16'h0F0F, 16'h0000, rd);
		check(rd, 16'h0F0F ^ 16'h3C3C);
		stop_test();
	end

	// Watchdog far beyond nine accesses of about eleven cycles each
	initial begin
		repeat (2000) @(posedge mclk);
		err_total++;
		stop_test();
	end
endmodule : tb

`default_nettype wire
